// >>> rtl/ccr_lock_bits.sv
// Purpose: Comparator 0 configuration bits and their write-once lock.
// Assumes: Write strobes are one cycle and already decoded.
// Notes: The strap level is sampled while the synchronous reset is high.
`include "ccr_params.svh"
`default_nettype none

module ccr_lock_bits (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_strap,
    input wire logic i_ctrl_we,
    input wire logic i_sleep_we,
    input wire logic i_lock_wr,
    input wire logic i_en_wr,
    input wire logic i_slp_wr,
    output logic o_lock,
    output logic o_en,
    output logic o_slp,
    output logic o_refused
);

    logic lock_q;
    logic en_q;
    logic slp_q;

    // Outside reset the lock only goes from zero to one; a zero write leaves it as it was.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            lock_q <= i_strap;
        end else if (i_ctrl_we && !lock_q && i_lock_wr) begin
            lock_q <= 1'b1;
        end
    end

    // Comparator 0 enable freezes with the lock.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            en_q <= i_strap;
        end else if (i_ctrl_we && !lock_q) begin
            en_q <= i_en_wr;
        end
    end

    // Comparator 0 deep-sleep enable freezes with the lock as well.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            slp_q <= `CCR_RST_BIT;
        end else if (i_sleep_we && !lock_q) begin
            slp_q <= i_slp_wr;
        end
    end

    // A write that tries to change a frozen bit is flagged, not applied.
    assign o_refused = lock_q && ((i_ctrl_we && (!i_lock_wr || (i_en_wr != en_q)))
                       || (i_sleep_we && (i_slp_wr != slp_q)));
    assign o_lock = lock_q;
    assign o_en = en_q;
    assign o_slp = slp_q;

endmodule

`default_nettype wire

// >>> rtl/ccr_params.svh
// Purpose: Offsets, field positions and reset values of the comparator control registers.
// Assumes: Byte addresses on an 8-bit register port with 32-bit data.
// Notes: Definitions only; included by its bare name.
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH

// Port widths.
`define CCR_ADDR_W 8
`define CCR_DATA_W 32
`define CCR_REG_W 8

// Register byte addresses.
`define CCR_ADDR_CTRL 8'h94
`define CCR_ADDR_SLEEP 8'h98
`define CCR_ADDR_STAT 8'h9c

// Control register fields.
`define CCR_CTRL_CMP0_EN 0
`define CCR_CTRL_LOCK 2
`define CCR_CTRL_SPARE 3
`define CCR_CTRL_CMP1_EN 4

// Sleep control register fields.
`define CCR_SLP_CMP0 0
`define CCR_SLP_CMP1 1

// Status register fields.
`define CCR_STAT_REFUSED 0
`define CCR_STAT_MISMATCH 1
`define CCR_STAT_LOCKED 2
`define CCR_STAT_STRAP 3

// Reset values of the plain read-write bits.
`define CCR_RST_BIT 1'b0
`define CCR_RST_BYTE 8'h00
`define CCR_RST_WORD 32'h0000_0000

`endif

// >>> rtl/ccr_pkg.sv
// Purpose: Types shared by the comparator control register files.
// Assumes: Nothing beyond the parameter header.
// Notes: Offsets and fields live in ccr_params.svh.
`default_nettype none

package ccr_pkg;

    // Which register an address selects.
    typedef enum logic [1:0] {
        CCR_SEL_NONE  = 2'h0,
        CCR_SEL_CTRL  = 2'h1,
        CCR_SEL_SLEEP = 2'h3,
        CCR_SEL_STAT  = 2'h2
    } ccr_sel_t;

    // One register's worth of bits.
    typedef logic [7:0] ccr_byte_t;

endpackage

`default_nettype wire

// >>> rtl/ccr_rd_port.sv
// Purpose: Registered read data for the comparator control registers.
// Assumes: A read strobe lasts one cycle.
// Notes: Data stands only in the cycle after the strobe and is zero otherwise.
`include "ccr_params.svh"
`default_nettype none

module ccr_rd_port (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_rd,
    input wire ccr_pkg::ccr_sel_t i_sel,
    input wire ccr_pkg::ccr_byte_t i_ctrl,
    input wire ccr_pkg::ccr_byte_t i_sleep,
    input wire ccr_pkg::ccr_byte_t i_stat,
    output logic [`CCR_DATA_W-1:0] o_rdata,
    output logic o_rvalid
);

    ccr_pkg::ccr_byte_t byte_d;
    logic [`CCR_DATA_W-1:0] rdata_q;
    logic rvalid_q;

    // Unmapped addresses read as zero; the upper bytes are always zero.
    always_comb begin
        case (i_sel)
            ccr_pkg::CCR_SEL_CTRL: byte_d = i_ctrl;
            ccr_pkg::CCR_SEL_SLEEP: byte_d = i_sleep;
            ccr_pkg::CCR_SEL_STAT: byte_d = i_stat;
            default: byte_d = `CCR_RST_BYTE;
        endcase
    end

    // Clearing the data outside the answer cycle keeps stale values off the bus.
    always_ff @(posedge i_clk) begin
        if (i_srst || !i_rd) begin
            rdata_q <= `CCR_RST_WORD;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= {{(`CCR_DATA_W-`CCR_REG_W){1'b0}}, byte_d};
            rvalid_q <= 1'b1;
        end
    end

    assign o_rdata = rdata_q;
    assign o_rvalid = rvalid_q;

endmodule

`default_nettype wire

// >>> rtl/ccr_top.sv
// Purpose: Control registers for two on-chip voltage comparators.
// Assumes: One 10 MHz clock, synchronous active-high system reset, strobes one cycle long.
// Notes: The analog comparators sit outside; this block only drives their enables.
//
// Behaviour
// - Control bit 4 switches comparator 1 on or off, is read-write and resets to zero.
// - Control bit 0 switches comparator 0 on or off and is writable only while unlocked.
// - With the comparator 0 lock set, control bits 2 to 0 ignore writes.
// - With the lock clear, control bit 0 reads and writes normally and a one written to bit 2 sets the lock; bit 1 reads as zero.
// - Reset loads the lock and comparator 0 enable with the strap pin level.
// - The lock is write-once and cannot be cleared by software until reset.
// - The lock also freezes the comparator 0 enable and deep-sleep enable.
// - Sleep bit 1 lets comparator 1 run in deep sleep, is read-write and resets to zero.
// - Sleep bit 0 lets comparator 0 run in deep sleep, resets to zero and freezes with the lock.
// - System reset returns every register and all logic to its default.
`include "ccr_params.svh"
`default_nettype none

module ccr_top (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_comparator_strap_pin,
    input wire logic [`CCR_ADDR_W-1:0] i_addr,
    input wire logic [`CCR_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [`CCR_DATA_W-1:0] o_rdata,
    output logic o_rvalid,
    output logic o_cmp0_en,
    output logic o_cmp1_en,
    output logic o_cmp0_sleep_en,
    output logic o_cmp1_sleep_en,
    output logic o_cmp0_locked,
    output logic o_sleep_mismatch
);

    // Address decode, used by both the write path and the read path.
    // An unmapped address selects nothing, so a stray write is dropped and a
    // stray read still answers, with zero, in the usual cycle.
    function automatic ccr_pkg::ccr_sel_t decode(input logic [`CCR_ADDR_W-1:0] addr);
        ccr_pkg::ccr_sel_t sel;
        sel = ccr_pkg::CCR_SEL_NONE;
        case (addr)
            `CCR_ADDR_CTRL: sel = ccr_pkg::CCR_SEL_CTRL;
            `CCR_ADDR_SLEEP: sel = ccr_pkg::CCR_SEL_SLEEP;
            `CCR_ADDR_STAT: sel = ccr_pkg::CCR_SEL_STAT;
            default: sel = ccr_pkg::CCR_SEL_NONE;
        endcase
        return sel;
    endfunction

    // Decoded strobes.
    ccr_pkg::ccr_sel_t wr_sel;
    ccr_pkg::ccr_sel_t rd_sel;
    logic ctrl_we;
    logic sleep_we;
    logic stat_we;

    // Plain read-write bits held here.
    // None of them is touched by the comparator 0 lock.
    logic cmp1_en_q;
    logic spare_q;
    logic cmp1_slp_q;

    // Status bits of this block's own making.
    // Firmware reads them at the status address; only bit 0 can be cleared.
    logic refused_q;
    logic refused_d;
    logic mismatch_q;
    logic mismatch_d;
    logic strap_seen_q;

    // Output flops for the enables, kept separate so every port is a flop.
    logic cmp0_en_out_q;
    logic cmp1_en_out_q;
    logic cmp0_slp_out_q;
    logic cmp1_slp_out_q;
    logic lock_out_q;

    // Wires from the locked group.
    logic lock_w;
    logic cmp0_en_w;
    logic cmp0_slp_w;
    logic refused_w;

    // Read-side images of each register.
    ccr_pkg::ccr_byte_t ctrl_img;
    ccr_pkg::ccr_byte_t sleep_img;
    ccr_pkg::ccr_byte_t stat_img;

    // Write decode; a read and a write never share a cycle.
    // Both selects come from the same address, so a read and a write to one
    // register always agree on what they address.
    assign wr_sel = decode(i_addr);
    assign rd_sel = decode(i_addr);
    assign ctrl_we = i_wr && (wr_sel == ccr_pkg::CCR_SEL_CTRL);
    assign sleep_we = i_wr && (wr_sel == ccr_pkg::CCR_SEL_SLEEP);
    assign stat_we = i_wr && (wr_sel == ccr_pkg::CCR_SEL_STAT);

    // Lock, comparator 0 enable and comparator 0 deep-sleep enable.
    // These three live together because the lock gates the other two; keeping
    // them in one module keeps the gating in one place.
    ccr_lock_bits u_lock (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_strap(i_comparator_strap_pin),
        .i_ctrl_we(ctrl_we),
        .i_sleep_we(sleep_we),
        .i_lock_wr(i_wdata[`CCR_CTRL_LOCK]),
        .i_en_wr(i_wdata[`CCR_CTRL_CMP0_EN]),
        .i_slp_wr(i_wdata[`CCR_SLP_CMP0]),
        .o_lock(lock_w),
        .o_en(cmp0_en_w),
        .o_slp(cmp0_slp_w),
        .o_refused(refused_w)
    );

    // Comparator 1 enable is never locked.
    // Only comparator 0 has a configuration lock, so this bit stays writable
    // for the whole run.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cmp1_en_q <= `CCR_RST_BIT;
        end else if (ctrl_we) begin
            cmp1_en_q <= i_wdata[`CCR_CTRL_CMP1_EN];
        end
    end

    // Bit 3 is a spare storage bit; it holds what is written, lock or not.
    // Firmware may use it as a scratch flag, so only reset or a write of zero clears it.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            spare_q <= `CCR_RST_BIT;
        end else if (ctrl_we) begin
            spare_q <= i_wdata[`CCR_CTRL_SPARE];
        end
    end

    // Comparator 1 deep-sleep enable is plain read-write.
    // Software is expected to keep it set while comparator 1 is enabled.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cmp1_slp_q <= `CCR_RST_BIT;
        end else if (sleep_we) begin
            cmp1_slp_q <= i_wdata[`CCR_SLP_CMP1];
        end
    end

    // Refused-write flag: sticky, write one to clear, and a new refusal in the
    // clearing cycle wins so the event is never lost.
    always_comb begin
        refused_d = refused_q;
        if (stat_we && i_wdata[`CCR_STAT_REFUSED]) begin
            refused_d = 1'b0;
        end
        if (refused_w) begin
            refused_d = 1'b1;
        end
    end

    // Refused-write flag register.
    // Reset clears it, so a refusal from before reset never survives it.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            refused_q <= `CCR_RST_BIT;
        end else begin
            refused_q <= refused_d;
        end
    end

    // The deep-sleep bit must accompany each enabled comparator; software owns
    // that pairing, so the block only reports a broken pair and does not fix it.
    assign mismatch_d = (cmp0_en_w && !cmp0_slp_w) || (cmp1_en_q && !cmp1_slp_q);

    // Mismatch flag register; being a flop, the port never carries a glitch
    // when an enable bit and a sleep bit change on the same edge.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            mismatch_q <= `CCR_RST_BIT;
        end else begin
            mismatch_q <= mismatch_d;
        end
    end

    // The strap level is caught during reset so firmware can tell whether it
    // still owes the lock write.
    // Outside reset the flop simply holds, so a strap pin that moves later
    // does not change what firmware reads.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            strap_seen_q <= i_comparator_strap_pin;
        end
    end

    // Enable outputs follow the stored bits one cycle later, costing one cycle
    // of latency in exchange for glitch-free drives to the analog side.
    // Each drive has its own flop process, and reset forces all of them low
    // so the comparators stay off until the stored bits have settled.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cmp0_en_out_q <= `CCR_RST_BIT;
        end else begin
            cmp0_en_out_q <= cmp0_en_w;
        end
    end

    // Comparator 1 enable drive.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cmp1_en_out_q <= `CCR_RST_BIT;
        end else begin
            cmp1_en_out_q <= cmp1_en_q;
        end
    end

    // Comparator 0 deep-sleep drive.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cmp0_slp_out_q <= `CCR_RST_BIT;
        end else begin
            cmp0_slp_out_q <= cmp0_slp_w;
        end
    end

    // Comparator 1 deep-sleep drive.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cmp1_slp_out_q <= `CCR_RST_BIT;
        end else begin
            cmp1_slp_out_q <= cmp1_slp_q;
        end
    end

    // Lock mirror for the rest of the system; it rises one cycle after the stored lock.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            lock_out_q <= `CCR_RST_BIT;
        end else begin
            lock_out_q <= lock_w;
        end
    end

    // Control register image; bits 7:5 and 1 read as zero.
    // The image is built from the stored bits, not the output flops, so a
    // read right after a write already shows the new value.
    always_comb begin
        ctrl_img = `CCR_RST_BYTE;
        ctrl_img[`CCR_CTRL_CMP0_EN] = cmp0_en_w;
        ctrl_img[`CCR_CTRL_LOCK] = lock_w;
        ctrl_img[`CCR_CTRL_SPARE] = spare_q;
        ctrl_img[`CCR_CTRL_CMP1_EN] = cmp1_en_q;
    end

    // Sleep control register image; bits 7:2 read as zero.
    always_comb begin
        sleep_img = `CCR_RST_BYTE;
        sleep_img[`CCR_SLP_CMP0] = cmp0_slp_w;
        sleep_img[`CCR_SLP_CMP1] = cmp1_slp_q;
    end

    // Status register image.
    // Bits 7:4 are unused and read as zero.
    always_comb begin
        stat_img = `CCR_RST_BYTE;
        stat_img[`CCR_STAT_REFUSED] = refused_q;
        stat_img[`CCR_STAT_MISMATCH] = mismatch_q;
        stat_img[`CCR_STAT_LOCKED] = lock_w;
        stat_img[`CCR_STAT_STRAP] = strap_seen_q;
    end

    // Read answer, registered for the cycle after the strobe.
    // The read port never stalls, so software needs no wait loop.
    ccr_rd_port u_rd (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_rd(i_rd),
        .i_sel(rd_sel),
        .i_ctrl(ctrl_img),
        .i_sleep(sleep_img),
        .i_stat(stat_img),
        .o_rdata(o_rdata),
        .o_rvalid(o_rvalid)
    );

    // Outputs to the comparators and to the system.
    // Each of these comes straight from a flop declared above.
    assign o_cmp0_en = cmp0_en_out_q;
    assign o_cmp1_en = cmp1_en_out_q;
    assign o_cmp0_sleep_en = cmp0_slp_out_q;
    assign o_cmp1_sleep_en = cmp1_slp_out_q;
    assign o_cmp0_locked = lock_out_q;
    assign o_sleep_mismatch = mismatch_q;

endmodule

`default_nettype wire

// >>> verification/ccr_top_chk.sv
// Purpose: Concurrent checks on the comparator control register ports.
// Assumes: One clock, synchronous active-high reset, one-cycle strobes.
// Notes: Enable outputs lag a write by two edges, so checks look two cycles ahead.
`include "ccr_params.svh"
`default_nettype none

module ccr_top_chk (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_comparator_strap_pin,
    input wire logic [`CCR_ADDR_W-1:0] i_addr,
    input wire logic [`CCR_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [`CCR_DATA_W-1:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic o_cmp0_en,
    input wire logic o_cmp1_en,
    input wire logic o_cmp0_sleep_en,
    input wire logic o_cmp1_sleep_en,
    input wire logic o_cmp0_locked,
    input wire logic o_sleep_mismatch
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    // Decoded write strobes of the two registers.
    logic wr_ctrl;
    logic wr_sleep;
    assign wr_ctrl = i_wr && (i_addr == `CCR_ADDR_CTRL);
    assign wr_sleep = i_wr && (i_addr == `CCR_ADDR_SLEEP);

    property p_lock_sticky;
        o_cmp0_locked |=> o_cmp0_locked;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock output dropped without reset");
    property p_en0_frozen;
        o_cmp0_locked |=> $stable(o_cmp0_en);
    endproperty
    a_en0_frozen: assert property (p_en0_frozen) else $error("comparator 0 enable changed while locked");
    property p_slp0_frozen;
        o_cmp0_locked |=> $stable(o_cmp0_sleep_en);
    endproperty
    a_slp0_frozen: assert property (p_slp0_frozen) else $error("comparator 0 sleep changed while locked");
    property p_rdata_hi;
        o_rvalid |-> (o_rdata[31:8] == 24'h000000);
    endproperty
    a_rdata_hi: assert property (p_rdata_hi) else $error("upper read data bits not zero");
    property p_rvalid;
        i_rd |=> o_rvalid;
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("read answer missing");
    property p_cmp1_wr;
        wr_ctrl |-> ##2 (o_cmp1_en == $past(i_wdata[4], 2));
    endproperty
    a_cmp1_wr: assert property (p_cmp1_wr) else $error("comparator 1 enable does not follow write");
    property p_cmp0_wr;
        wr_ctrl && !o_cmp0_locked && !$past(i_wr) && !$past(i_srst) && !$past(i_srst, 2)
            |-> ##2 (o_cmp0_en == $past(i_wdata[0], 2));
    endproperty
    a_cmp0_wr: assert property (p_cmp0_wr) else $error("comparator 0 enable does not follow write");
    property p_lock_set;
        wr_ctrl && i_wdata[2] |-> ##2 o_cmp0_locked;
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("lock write did not set lock");
    property p_slp1_wr;
        wr_sleep |-> ##2 (o_cmp1_sleep_en == $past(i_wdata[1], 2));
    endproperty
    a_slp1_wr: assert property (p_slp1_wr) else $error("comparator 1 sleep does not follow write");
    property p_reset_out;
        $fell(i_srst) |-> !o_cmp1_en && !o_cmp1_sleep_en && !o_rvalid;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not cleared by reset");
    property p_rvalid_once;
        !i_rd |=> !o_rvalid;
    endproperty
    a_rvalid_once: assert property (p_rvalid_once) else $error("read answer without a read");
    property p_strap_load;
        $fell(i_srst) |=> (o_cmp0_locked == $past(i_comparator_strap_pin, 2))
            && (o_cmp0_en == $past(i_comparator_strap_pin, 2));
    endproperty
    a_strap_load: assert property (p_strap_load) else $error("lock or enable 0 not loaded from strap");
endmodule

bind ccr_top ccr_top_chk u_ccr_top_chk (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_comparator_strap_pin(i_comparator_strap_pin),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .o_rvalid(o_rvalid),
    .o_cmp0_en(o_cmp0_en),
    .o_cmp1_en(o_cmp1_en),
    .o_cmp0_sleep_en(o_cmp0_sleep_en),
    .o_cmp1_sleep_en(o_cmp1_sleep_en),
    .o_cmp0_locked(o_cmp0_locked),
    .o_sleep_mismatch(o_sleep_mismatch)
);

`default_nettype wire

// >>> verification/tb_ccr_top.sv
// Purpose: Self-checking bench for the comparator control registers.
// Assumes: Strobes one cycle long, read data only in the cycle after the strobe.
// Notes: Runs once with the strap low and once high to cover both lock defaults.
`include "ccr_params.svh"
`default_nettype none

module tb_ccr_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic strap = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    wire logic [31:0] rdata;
    wire logic rvalid, en0, en1, sl0, sl1, lk, mm;
    int n_errors = 0;
    int comparisons = 0;

    ccr_top u_ccr_top (.i_clk(i_clk), .i_srst(i_srst), .i_comparator_strap_pin(strap), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_rvalid(rvalid), .o_cmp0_en(en0),
        .o_cmp1_en(en1), .o_cmp0_sleep_en(sl0), .o_cmp1_sleep_en(sl1), .o_cmp0_locked(lk),
        .o_sleep_mismatch(mm));

    // A 100 ns period gives the 10 MHz clock.
    always #50 i_clk = ~i_clk;

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Reset is held for 20 cycles with the strap level steady throughout.
    task automatic do_reset(input logic s);
        @(posedge i_clk);
        i_srst <= 1'b1;
        strap <= s;
        repeat (20) @(posedge i_clk);
        i_srst <= 1'b0;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= {24'h000000, d};
        @(posedge i_clk);
        wr <= 1'b0;
    endtask

    // The answer is sampled just after the edge that launched it, where it stands one cycle.
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge i_clk);
        rd <= 1'b0;
        #1;
        chk("rvalid", 32'h1, {31'h0, rvalid});
        chk("rdata", {24'h000000, e}, rdata);
    endtask

    // Order is mismatch, lock, sleep 1, sleep 0, enable 1, enable 0.
    task automatic outs(input logic [5:0] e);
        chk("outputs", {26'h0, e}, {26'h0, mm, lk, sl1, sl0, en1, en0});
    endtask

    initial begin
        repeat (5000) @(posedge i_clk);
        n_errors++;
        $display("unexpected run length expected done seen running");
        results();
    end

    // Writes are always followed by a read, which leaves the two edges the outputs need.
    initial begin
        do_reset(1'b0);
        rd_reg(`CCR_ADDR_CTRL, 8'h00);
        rd_reg(`CCR_ADDR_SLEEP, 8'h00);
        outs(6'h00);
        wr_reg(`CCR_ADDR_CTRL, 8'hfb);
        rd_reg(`CCR_ADDR_CTRL, 8'h19);
        outs(6'h23);
        wr_reg(`CCR_ADDR_SLEEP, 8'hff);
        rd_reg(`CCR_ADDR_SLEEP, 8'h03);
        outs(6'h0f);
        wr_reg(8'h00, 8'hff);
        rd_reg(8'h00, 8'h00);
        rd_reg(`CCR_ADDR_CTRL, 8'h19);
        wr_reg(`CCR_ADDR_CTRL, 8'h04);
        rd_reg(`CCR_ADDR_CTRL, 8'h04);
        wr_reg(`CCR_ADDR_CTRL, 8'h1b);
        rd_reg(`CCR_ADDR_CTRL, 8'h1c);
        rd_reg(`CCR_ADDR_STAT, 8'h05);
        wr_reg(`CCR_ADDR_STAT, 8'h01);
        rd_reg(`CCR_ADDR_STAT, 8'h04);
        wr_reg(`CCR_ADDR_SLEEP, 8'h00);
        rd_reg(`CCR_ADDR_SLEEP, 8'h01);
        outs(6'h36);
        rd_reg(`CCR_ADDR_STAT, 8'h07);
        wr_reg(`CCR_ADDR_SLEEP, 8'h03);
        rd_reg(`CCR_ADDR_SLEEP, 8'h03);
        outs(6'h1e);
        $display("test strap low done");
        do_reset(1'b1);
        rd_reg(`CCR_ADDR_CTRL, 8'h05);
        rd_reg(`CCR_ADDR_SLEEP, 8'h00);
        outs(6'h31);
        rd_reg(`CCR_ADDR_STAT, 8'h0e);
        wr_reg(`CCR_ADDR_CTRL, 8'h0c);
        rd_reg(`CCR_ADDR_CTRL, 8'h0d);
        wr_reg(`CCR_ADDR_CTRL, 8'h00);
        rd_reg(`CCR_ADDR_CTRL, 8'h05);
        wr_reg(`CCR_ADDR_SLEEP, 8'h01);
        rd_reg(`CCR_ADDR_SLEEP, 8'h00);
        $display("test strap high done");
        results();
    end
endmodule

`default_nettype wire
